// >>> atas_far.sv
`timescale 1ns/1ps
module atas_far #(
   parameter int NPIX = 4  // Pixels per readout
) (
   input  wire logic        i_clk,       // System clock
   input  wire logic        i_fire,      // Start one trigger pulse
   input  wire logic [7:0]  i_width,     // Pulse high time in cycles
   input  wire logic        i_send,      // Start one readout
   input  wire logic [15:0] i_base,      // Value of pixel 0
   output logic             o_trig,      // Trigger pin
   output logic             o_pix_valid, // Pixel strobe
   output logic [15:0]      o_pix_data   // Pixel value
);
   logic [7:0] hi_left;
   logic [7:0] px_left;
   initial begin
      hi_left = 8'h0;
      px_left = 8'h0;
      o_trig = 1'h0;
      o_pix_valid = 1'h0;
      o_pix_data = 16'h0;
   end
   always @(posedge i_clk) begin
      hi_left <= i_fire ? i_width : (hi_left != 8'h0 ? hi_left - 8'h1 : 8'h0);
      o_trig <= i_fire || hi_left > 8'h1;
      px_left <= i_send ? 8'(NPIX) : (px_left != 8'h0 ? px_left - 8'h1 : 8'h0);
      o_pix_valid <= px_left != 8'h0;
      // Off-strobe data toggles so a stale value is never mistaken for a pixel
      o_pix_data <= px_left != 8'h0 ? i_base + 16'(NPIX - px_left) : ~o_pix_data;
   end
endmodule

// >>> atas_pkg.sv
package atas_pkg;
   localparam int CLK_MHZ       = 125;
   localparam int CLK_NS        = 8;
   localparam int TICK_US       = 1;
   localparam int TICK_CYC      = CLK_MHZ * TICK_US;
   localparam int ETRG_MIN_NS   = 20;
   localparam int ETRG_MAX_NS   = 30;
   localparam int ETRG_MIN_CYC  = (ETRG_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int ETRG_MAX_CYC  = ETRG_MAX_NS / CLK_NS;
   localparam int ACQ_MAX_US    = 335500;
   localparam int LEVEL_MIN_US  = 3800;
   localparam int LEVEL_MAX_US  = 10000000;
   localparam int INIT_BUSY_US  = 3706;
   localparam int INTER_BUSY_US = 0;
   localparam int FINAL_BUSY_US = 3706;
   localparam int AVG_MIN       = 2;
   localparam int AVG_MAX       = 65535;
   localparam int TW            = 24;
   localparam int NW            = 16;

   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_ACQ    = 12'h008;
   localparam logic [11:0] OFS_INTEG  = 12'h00c;
   localparam logic [11:0] OFS_SSDLY  = 12'h010;
   localparam logic [11:0] OFS_SSW    = 12'h014;
   localparam logic [11:0] OFS_CSPER  = 12'h018;
   localparam logic [11:0] OFS_CSOFF  = 12'h01c;
   localparam logic [11:0] OFS_NAVG   = 12'h020;
   localparam logic [11:0] OFS_LVLW   = 12'h024;
   localparam logic [9:0]  AVG_W0     = 10'h100;

   localparam int CTRL_GO       = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_AVG      = 3;
   localparam int CTRL_SS_EN    = 4;
   localparam int CTRL_CS_EN    = 5;
   localparam int STAT_RUN      = 0;
   localparam int STAT_ST_LSB   = 1;
   localparam int STAT_LERR     = 4;
   localparam int STAT_CERR     = 5;
   localparam int STAT_CNT_LSB  = 16;
   localparam int HTRANS_ACT    = 1;

   typedef enum logic [1:0] {
      TRG_SW    = 2'h0,
      TRG_EDGE  = 2'h1,
      TRG_LEVEL = 2'h2
   } atas_trig_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DELAY = 3'h1,
      ST_BUSY1 = 3'h3,
      ST_INTEG = 3'h2,
      ST_INTER = 3'h6,
      ST_FINAL = 3'h7
   } atas_state_t;
endpackage

// >>> atas_seq.sv
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Level trigger: integration lasts as long as the trigger stayed high.
// - Trigger event follows an external rising edge by 20 to 30 ns.
// - Programmable acquisition delay, 0 to 335500 us in 1 us steps.
// - Single strobe delay and width in us; forced low at integration end.
// - Continuous strobe period in us; forced low at end of integration.
// - Averaging runs several integrations and returns per-pixel averages.
// - Integration count is programmable from 2 to 65535.
// - Averaging accepts software or edge trigger only, never level.
// - Software trigger raises the event when the request is recognised.
// - Edge trigger in averaging raises the event after a fixed short delay.
// - Averaged integrations run back to back with no busy gap.
// - Averaging: single strobe forced low when the first integration ends.
// - Averaging: continuous strobe runs only if period below integration time.
// - Continuous strobe off time is limited to the strobe period.
// - Too short level pulse flags an error and yields an all-zero spectrum.
// - Single strobe delay is counted from the trigger event.
// - Disabled single strobe stays low.
module atas_seq #(
   parameter int TICK_DIV      = atas_pkg::TICK_CYC,      // Cycles per microsecond
   parameter int NPIX          = 64,                      // Pixels per spectrum
   parameter int INIT_BUSY_US  = atas_pkg::INIT_BUSY_US,  // Busy before integration
   parameter int INTER_BUSY_US = atas_pkg::INTER_BUSY_US, // Busy between integrations
   parameter int FINAL_BUSY_US = atas_pkg::FINAL_BUSY_US, // Busy after last integration
   parameter int LEVEL_MIN_US  = atas_pkg::LEVEL_MIN_US,  // Shortest level pulse
   parameter int LEVEL_MAX_US  = atas_pkg::LEVEL_MAX_US   // Longest level pulse
) (
   input  wire logic        i_clk,           // System clock, 125 MHz
   input  wire logic        i_rst,           // Synchronous reset, active high
   input  wire logic        i_ce,            // Clock enable, freezes all state
   input  wire logic        i_hsel,          // AHB-Lite select
   input  wire logic [31:0] i_haddr,         // AHB-Lite address
   input  wire logic [1:0]  i_htrans,        // AHB-Lite transfer type
   input  wire logic        i_hwrite,        // AHB-Lite write
   input  wire logic [2:0]  i_hsize,         // AHB-Lite size, word only
   input  wire logic [31:0] i_hwdata,        // AHB-Lite write data
   input  wire logic        i_hready,        // AHB-Lite bus ready
   output logic             o_hreadyout,     // AHB-Lite slave ready
   output logic             o_hresp,         // AHB-Lite response, always OKAY
   output logic [31:0]      o_hrdata,        // AHB-Lite read data
   input  wire logic        i_ext_trig,      // External trigger pin
   input  wire logic        i_pix_valid,     // Detector pixel strobe
   input  wire logic [15:0] i_pix_data,      // Detector pixel value
   output logic             o_single_strobe, // Single strobe pin
   output logic             o_cont_strobe,   // Continuous strobe pin
   output logic             o_integrating    // High during integration
);
   localparam int TW = atas_pkg::TW;
   localparam int NW = atas_pkg::NW;
   localparam int PW = $clog2(NPIX);
   localparam logic [TW-1:0] INIT_L  = TW'(INIT_BUSY_US);
   localparam logic [TW-1:0] INTER_L = TW'(INTER_BUSY_US);
   localparam logic [TW-1:0] FINAL_L = TW'(FINAL_BUSY_US);
   localparam logic [TW-1:0] LMIN_L  = TW'(LEVEL_MIN_US);
   localparam logic [TW-1:0] LMAX_L  = TW'(LEVEL_MAX_US);
   localparam logic [TW-1:0] ACQ_L   = TW'(atas_pkg::ACQ_MAX_US);
   localparam logic [NW-1:0] NMIN_L  = NW'(atas_pkg::AVG_MIN);

   generate
      if (TICK_DIV < 2 || NPIX < 2 || NPIX > 256 || LEVEL_MIN_US < 1 ||
          LEVEL_MAX_US >= 2**TW || INIT_BUSY_US < 1 || FINAL_BUSY_US < 1) begin : g_bad
         $error("atas_seq: unsupported parameter values");
      end
   endgenerate

   logic                  tick;
   logic                  trig_s;
   logic                  trig_d;
   logic                  edge_q;
   logic                  edge_evt;
   logic                  ap_wr;
   logic                  ap_rd;
   logic [11:0]           ap_addr;
   logic [31:0]           rd_mux;
   atas_pkg::atas_trig_t  trig_mode;
   logic                  avg_en;
   logic                  ss_en;
   logic                  cs_en;
   logic                  sw_go;
   logic [TW-1:0]         acq_dly;
   logic [TW-1:0]         integ_us;
   logic [TW-1:0]         ss_dly;
   logic [TW-1:0]         ss_w;
   logic [TW-1:0]         cs_per;
   logic [TW-1:0]         cs_off;
   logic [NW-1:0]         navg;
   atas_pkg::atas_state_t st;
   atas_pkg::atas_state_t next_st;
   logic [TW-1:0]         cnt;
   logic [TW-1:0]         lim;
   logic [TW-1:0]         ss_cnt;
   logic [TW-1:0]         cs_cnt;
   logic [TW-1:0]         hi_us;
   logic [TW-1:0]         off_eff;
   logic                  lvl_on;
   logic                  lvl_done;
   logic                  lvl_err;
   logic                  ss_cut;
   logic [NW-1:0]         integ_k;
   logic [NW-1:0]         n_eff;
   logic                  level_sel;
   logic                  cfg_err;
   logic                  evt;
   logic                  st_done;
   logic                  integ_end;
   logic                  more;
   logic                  cs_allow;
   logic                  next_ss;
   logic                  next_cs;
   logic [PW-1:0]         pix_idx;
   logic                  first_pass;
   logic [31:0]           acc [NPIX];
   logic [9:0]            widx;
   logic [PW-1:0]         aidx;

   atas_tick #(.DIV(TICK_DIV)) u_tick (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_ce   (i_ce),
      .o_tick (tick)
   );

   atas_sync u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_async (i_ext_trig),
      .o_sync  (trig_s)
   );

   // AHB-Lite slave: writes take no wait state, reads one
   wire ahb_go = i_hsel & i_htrans[atas_pkg::HTRANS_ACT] & i_hready;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ap_wr <= 1'b0;
         ap_rd <= 1'b0;
         ap_addr <= '0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         o_hrdata <= '0;
      end else if (i_ce) begin
         ap_wr <= ahb_go & i_hwrite;
         ap_rd <= ahb_go & ~i_hwrite;
         if (ahb_go) begin
            ap_addr <= i_haddr[11:0];
         end
         o_hreadyout <= ~(ahb_go & ~i_hwrite);
         o_hresp <= 1'b0;
         if (ap_rd) begin
            o_hrdata <= rd_mux;
         end
      end
   end

   assign widx = ap_addr[11:2];
   assign aidx = PW'(widx - atas_pkg::AVG_W0);

   always_comb begin
      rd_mux = '0;
      if (widx >= atas_pkg::AVG_W0 && widx < atas_pkg::AVG_W0 + 10'(NPIX)) begin
         rd_mux = lvl_err ? '0 : acc[aidx] / {16'h0000, n_eff};
      end else begin
         case (ap_addr)
            atas_pkg::OFS_CTRL: begin
               rd_mux[atas_pkg::CTRL_MODE_LSB +: 2] = trig_mode;
               rd_mux[atas_pkg::CTRL_AVG] = avg_en;
               rd_mux[atas_pkg::CTRL_SS_EN] = ss_en;
               rd_mux[atas_pkg::CTRL_CS_EN] = cs_en;
            end
            atas_pkg::OFS_STATUS: begin
               rd_mux[atas_pkg::STAT_RUN] = (st != atas_pkg::ST_IDLE);
               rd_mux[atas_pkg::STAT_ST_LSB +: 3] = st;
               rd_mux[atas_pkg::STAT_LERR] = lvl_err;
               rd_mux[atas_pkg::STAT_CERR] = cfg_err;
               rd_mux[atas_pkg::STAT_CNT_LSB +: NW] = integ_k;
            end
            atas_pkg::OFS_ACQ:   rd_mux[TW-1:0] = acq_dly;
            atas_pkg::OFS_INTEG: rd_mux[TW-1:0] = integ_us;
            atas_pkg::OFS_SSDLY: rd_mux[TW-1:0] = ss_dly;
            atas_pkg::OFS_SSW:   rd_mux[TW-1:0] = ss_w;
            atas_pkg::OFS_CSPER: rd_mux[TW-1:0] = cs_per;
            atas_pkg::OFS_CSOFF: rd_mux[TW-1:0] = cs_off;
            atas_pkg::OFS_NAVG:  rd_mux[NW-1:0] = navg;
            atas_pkg::OFS_LVLW:  rd_mux[TW-1:0] = hi_us;
            default:             rd_mux = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         trig_mode <= atas_pkg::TRG_SW;
         avg_en <= 1'b0;
         ss_en <= 1'b0;
         cs_en <= 1'b0;
         sw_go <= 1'b0;
         acq_dly <= '0;
         integ_us <= LMIN_L;
         ss_dly <= '0;
         ss_w <= '0;
         cs_per <= '0;
         cs_off <= '0;
         navg <= NMIN_L;
      end else if (i_ce) begin
         sw_go <= 1'b0;
         if (ap_wr) begin
            case (ap_addr)
               atas_pkg::OFS_CTRL: begin
                  trig_mode <= atas_pkg::atas_trig_t'(i_hwdata[atas_pkg::CTRL_MODE_LSB +: 2]);
                  avg_en <= i_hwdata[atas_pkg::CTRL_AVG];
                  ss_en <= i_hwdata[atas_pkg::CTRL_SS_EN];
                  cs_en <= i_hwdata[atas_pkg::CTRL_CS_EN];
                  sw_go <= i_hwdata[atas_pkg::CTRL_GO];
               end
               atas_pkg::OFS_ACQ:
                  acq_dly <= (i_hwdata > 32'(ACQ_L)) ? ACQ_L : i_hwdata[TW-1:0];
               atas_pkg::OFS_INTEG: integ_us <= i_hwdata[TW-1:0];
               atas_pkg::OFS_SSDLY: ss_dly <= i_hwdata[TW-1:0];
               atas_pkg::OFS_SSW:   ss_w <= i_hwdata[TW-1:0];
               atas_pkg::OFS_CSPER: cs_per <= i_hwdata[TW-1:0];
               atas_pkg::OFS_CSOFF: cs_off <= i_hwdata[TW-1:0];
               atas_pkg::OFS_NAVG:
                  navg <= (i_hwdata[NW-1:0] < NMIN_L) ? NMIN_L : i_hwdata[NW-1:0];
               default: ;
            endcase
         end
      end
   end

   // Trigger event pipeline after the synchroniser
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         trig_d <= 1'b0;
         edge_q <= 1'b0;
         edge_evt <= 1'b0;
      end else if (i_ce) begin
         trig_d <= trig_s;
         edge_q <= trig_s & ~trig_d;
         edge_evt <= edge_q;
      end
   end

   assign level_sel = (trig_mode == atas_pkg::TRG_LEVEL) && !avg_en;
   assign cfg_err = avg_en && (trig_mode == atas_pkg::TRG_LEVEL);
   assign evt = (st == atas_pkg::ST_IDLE) && !cfg_err &&
                (((trig_mode == atas_pkg::TRG_SW) && sw_go) ||
                 ((trig_mode == atas_pkg::TRG_EDGE || level_sel) && edge_evt));
   assign n_eff = avg_en ? navg : NW'(1);
   assign more = ({1'b0, integ_k} + 17'h00001) < {1'b0, n_eff};

   always_comb begin
      case (st)
         atas_pkg::ST_DELAY: lim = acq_dly;
         atas_pkg::ST_BUSY1: lim = INIT_L;
         atas_pkg::ST_INTEG: lim = level_sel ? hi_us : integ_us;
         atas_pkg::ST_INTER: lim = INTER_L;
         atas_pkg::ST_FINAL: lim = FINAL_L;
         default:            lim = '0;
      endcase
   end

   assign st_done = ((lim == '0) || (tick && cnt >= lim - 1'b1)) &&
                    !(st == atas_pkg::ST_INTEG && level_sel && !lvl_done);
   assign integ_end = (st == atas_pkg::ST_INTEG) && st_done;

   always_comb begin
      next_st = st;
      case (st)
         atas_pkg::ST_IDLE:  if (evt) next_st = atas_pkg::ST_DELAY;
         atas_pkg::ST_DELAY: if (st_done) next_st = atas_pkg::ST_BUSY1;
         atas_pkg::ST_BUSY1: if (st_done) next_st = atas_pkg::ST_INTEG;
         atas_pkg::ST_INTEG: begin
            if (st_done && !more) begin
               next_st = atas_pkg::ST_FINAL;
            end else if (st_done && INTER_L != '0) begin
               next_st = atas_pkg::ST_INTER;
            end
         end
         atas_pkg::ST_INTER: if (st_done) next_st = atas_pkg::ST_INTEG;
         atas_pkg::ST_FINAL: if (st_done) next_st = atas_pkg::ST_IDLE;
         default:            next_st = atas_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st <= atas_pkg::ST_IDLE;
         cnt <= '0;
         integ_k <= '0;
      end else if (i_ce) begin
         st <= next_st;
         if (next_st != st || integ_end) begin
            cnt <= '0;
         end else if (tick && cnt != '1) begin
            cnt <= cnt + 1'b1;
         end
         if (evt) begin
            integ_k <= '0;
         end else if (integ_end) begin
            integ_k <= integ_k + 1'b1;
         end
      end
   end

   // High time of the level trigger, measured from the event
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lvl_on <= 1'b0;
         lvl_done <= 1'b1;
         lvl_err <= 1'b0;
         hi_us <= '0;
      end else if (i_ce) begin
         if (evt) begin
            lvl_on <= level_sel;
            lvl_done <= !level_sel;
            lvl_err <= 1'b0;
            hi_us <= '0;
         end else if (lvl_on) begin
            if (!trig_s) begin
               lvl_on <= 1'b0;
               lvl_done <= 1'b1;
               lvl_err <= (hi_us < LMIN_L);
            end else if (tick && hi_us < LMAX_L) begin
               hi_us <= hi_us + 1'b1;
            end
         end
      end
   end

   assign off_eff = (cs_off > cs_per) ? cs_per : cs_off;
   assign cs_allow = cs_en && (cs_per != '0) &&
                     (level_sel || cs_per < integ_us);
   assign next_ss = ss_en && (st != atas_pkg::ST_IDLE) && !ss_cut &&
                    !(integ_end && integ_k == '0) &&
                    (ss_cnt >= ss_dly) && (ss_cnt - ss_dly < ss_w);
   assign next_cs = cs_allow && (st == atas_pkg::ST_INTEG) &&
                    !(integ_end && !more) && (cs_cnt >= off_eff);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ss_cnt <= '0;
         ss_cut <= 1'b0;
         cs_cnt <= '0;
         o_single_strobe <= 1'b0;
         o_cont_strobe <= 1'b0;
         o_integrating <= 1'b0;
      end else if (i_ce) begin
         if (evt) begin
            ss_cnt <= '0;
         end else if (tick && ss_cnt != '1) begin
            ss_cnt <= ss_cnt + 1'b1;
         end
         if (evt) begin
            ss_cut <= 1'b0;
         end else if (integ_end) begin
            ss_cut <= 1'b1;
         end
         if (st != atas_pkg::ST_INTEG) begin
            cs_cnt <= '0;
         end else if (tick) begin
            cs_cnt <= (cs_cnt >= cs_per - 1'b1) ? '0 : cs_cnt + 1'b1;
         end
         o_single_strobe <= next_ss;
         o_cont_strobe <= next_cs;
         o_integrating <= (next_st == atas_pkg::ST_INTEG);
      end
   end

   // Per-pixel accumulation over all integrations of a cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pix_idx <= '0;
         first_pass <= 1'b1;
      end else if (i_ce) begin
         if (evt) begin
            pix_idx <= '0;
            first_pass <= 1'b1;
         end else if (i_pix_valid) begin
            if (pix_idx == PW'(NPIX - 1)) begin
               pix_idx <= '0;
               first_pass <= 1'b0;
            end else begin
               pix_idx <= pix_idx + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_ce && i_pix_valid && !evt) begin
         acc[pix_idx] <= first_pass ? {16'h0000, i_pix_data}
                                    : acc[pix_idx] + {16'h0000, i_pix_data};
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   property p_evt_delay;
      i_ce && trig_s && !trig_d ##1 i_ce |=> edge_evt;
   endproperty
   a_evt_delay: assert property (p_evt_delay) else $error("edge event late");

   property p_sw_evt;
      i_ce && st == atas_pkg::ST_IDLE && sw_go && trig_mode == atas_pkg::TRG_SW && !cfg_err
         |=> st == atas_pkg::ST_DELAY;
   endproperty
   a_sw_evt: assert property (p_sw_evt) else $error("software trigger ignored");

   property p_ss_off;
      i_ce && !ss_en |=> !o_single_strobe;
   endproperty
   a_ss_off: assert property (p_ss_off) else $error("disabled strobe high");

   property p_ss_cut;
      i_ce && integ_end && integ_k == '0 |=> !o_single_strobe ##1 (!i_ce || !o_single_strobe);
   endproperty
   a_ss_cut: assert property (p_ss_cut) else $error("single strobe not cut");

   property p_cs_end;
      i_ce && integ_end && !more |=> !o_cont_strobe && !o_integrating;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("cont strobe after end");

   property p_lvl_err;
      i_ce && lvl_on && !trig_s && hi_us < LMIN_L |=> lvl_err;
   endproperty
   a_lvl_err: assert property (p_lvl_err) else $error("short pulse not flagged");

   property p_no_level_avg;
      i_ce && cfg_err && st == atas_pkg::ST_IDLE |=> st == atas_pkg::ST_IDLE;
   endproperty
   a_no_level_avg: assert property (p_no_level_avg) else $error("level in averaging");

   property p_b2b;
      i_ce && integ_end && more && INTER_L == '0 |=> st == atas_pkg::ST_INTEG && cnt == '0;
   endproperty
   a_b2b: assert property (p_b2b) else $error("gap between integrations");

   property p_ss_rise;
      i_ce && !o_single_strobe ##1 o_single_strobe |-> $past(ss_cnt) >= $past(ss_dly);
   endproperty
   a_ss_rise: assert property (p_ss_rise) else $error("strobe before delay");

   property p_tick;
      i_ce && tick |=> !tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too dense");

   c_avg: cover property (integ_end && more && avg_en);
   c_level: cover property (integ_end && level_sel);
   c_ss: cover property ($rose(o_single_strobe));
   c_cs: cover property ($rose(o_cont_strobe));
endmodule

// >>> atas_sync.sv
`timescale 1ns/1ps
module atas_sync (
   input  wire logic i_clk,    // System clock
   input  wire logic i_rst,    // Synchronous reset, active high
   input  wire logic i_ce,     // Clock enable
   input  wire logic i_async,  // Level from outside the clock domain
   output logic      o_sync    // Synchronised level
);
   logic meta;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta <= 1'b0;
         o_sync <= 1'b0;
      end else if (i_ce) begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// >>> atas_tick.sv
`timescale 1ns/1ps
module atas_tick #(
   parameter int DIV = atas_pkg::TICK_CYC
) (
   input  wire logic i_clk,   // System clock
   input  wire logic i_rst,   // Synchronous reset, active high
   input  wire logic i_ce,    // Clock enable
   output logic      o_tick   // One-cycle pulse every microsecond
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         o_tick <= (cnt == CW'(DIV - 1));
         cnt <= (cnt == CW'(DIV - 1)) ? '0 : cnt + 1'b1;
      end
   end
endmodule

// >>> test_acquisition_trigger_averaging_sequencer.sv
`timescale 1ns/1ps
module test_acquisition_trigger_averaging_sequencer;
   typedef struct {logic w; logic [31:0] a, d, e;} atas_row_t;
   logic        clk, rst, ce, hsel, hwrite, fire, send, trig, pv, rdy, resp, ss, cs, integ;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0]  width;
   logic [15:0] base, pd;
   int          err_count, checked, icnt, ssbad, sshi, cshi, k, n;
   atas_row_t   rows [14] = '{'{1'h0, 32'h00c, 32'h0, 32'h5},
      '{1'h0, 32'h020, 32'h0, 32'h2}, '{1'h1, 32'h008, 32'h61a80, 32'h0},
      '{1'h0, 32'h008, 32'h0, 32'h51e8c}, '{1'h1, 32'h020, 32'h1, 32'h0},
      '{1'h0, 32'h020, 32'h0, 32'h2}, '{1'h0, 32'h300, 32'h0, 32'h0},
      '{1'h1, 32'h008, 32'h0, 32'h0}, '{1'h1, 32'h00c, 32'h5, 32'h0},
      '{1'h1, 32'h020, 32'h3, 32'h0}, '{1'h1, 32'h014, 32'h64, 32'h0},
      '{1'h1, 32'h018, 32'h2, 32'h0}, '{1'h1, 32'h01c, 32'h1, 32'h0},
      '{1'h0, 32'h01c, 32'h0, 32'h1}};
   atas_seq #(.TICK_DIV(4), .NPIX(4), .INIT_BUSY_US(3), .FINAL_BUSY_US(3),
      .LEVEL_MIN_US(5)) u_dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(resp),
      .o_hrdata(hrdata), .i_ext_trig(trig), .i_pix_valid(pv), .i_pix_data(pd),
      .o_single_strobe(ss), .o_cont_strobe(cs), .o_integrating(integ));
   atas_far u_far (.i_clk(clk), .i_fire(fire), .i_width(width),
      .i_send(send), .i_base(base), .o_trig(trig), .o_pix_valid(pv), .o_pix_data(pd));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (integ === 1'h1) icnt++;
      if (cs === 1'h1) cshi++;
      if (ss === 1'h1) begin
         sshi++;
         if (icnt > 22) ssbad++;
      end
   end
   task summarize;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Waits for a rising edge at which hready is sampled high
   task ack;
      k = 0;
      @(posedge clk);
      while (rdy !== 1'h1 && k < 50) begin
         k++;
         @(posedge clk);
      end
      rd = hrdata;
      chk("hresp", 32'h0, 32'(resp));
      if (k == 50) begin
         err_count++;
         summarize;
      end
   endtask
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      ack;
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      ack;
   endtask
   task pulse(input logic [7:0] wd);
      width <= wd;
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
   endtask
   task readout(input logic [15:0] b);
      base <= b;
      send <= 1'h1;
      @(posedge clk);
      send <= 1'h0;
      repeat (5) @(posedge clk);
   endtask
   task idle;
      repeat (8) @(posedge clk);
      n = 0;
      bus(1'h0, 32'h004, 32'h0);
      while (rd[0] !== 1'h0 && n < 100) begin
         n++;
         bus(1'h0, 32'h004, 32'h0);
      end
      if (n == 100) begin
         err_count++;
         summarize;
      end
   endtask
   initial begin
      {rst, hsel, hwrite, fire, send, htrans, haddr, hwdata, width, base, hsize} = '0;
      rst = 1'h1;
      ce = 1'h1;
      {err_count, checked, icnt, ssbad, sshi, cshi} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk("register", rows[i].e, rd);
      end
      icnt = 0;
      bus(1'h1, 32'h000, 32'h39);
      readout(16'h30);
      readout(16'h60);
      readout(16'h90);
      idle;
      chk("integrating cycles", 32'h1, 32'(icnt >= 56 && icnt <= 60));
      chk("strobe late", 32'h0, 32'(ssbad));
      chk("strobe seen", 32'h1, 32'(sshi > 0));
      chk("cont strobe cycles", 32'h1c, 32'(cshi));
      chk("done count", 32'h3, 32'(rd[31:16]));
      bus(1'h0, 32'h404, 32'h0);
      chk("average", 32'h61, rd);
      bus(1'h1, 32'h000, 32'hc);
      pulse(8'd40);
      repeat (8) @(posedge clk);
      bus(1'h0, 32'h004, 32'h0);
      chk("config error", 32'h1, 32'(rd[5]));
      chk("running", 32'h0, 32'(rd[0]));
      repeat (40) @(posedge clk);
      bus(1'h1, 32'h000, 32'h4);
      icnt = 0;
      pulse(8'd40);
      idle;
      chk("level integration", 32'h1, 32'(icnt >= 36 && icnt <= 44));
      pulse(8'd8);
      idle;
      chk("level error", 32'h1, 32'(rd[4]));
      bus(1'h0, 32'h400, 32'h0);
      chk("zero spectrum", 32'h0, rd);
      bus(1'h1, 32'h000, 32'ha);
      pulse(8'd2);
      idle;
      chk("edge event", 32'h0, 32'(rd[4]));
      chk("edge count", 32'h3, 32'(rd[31:16]));
      ce <= 1'h0;
      bus(1'h1, 32'h008, 32'h7);
      ce <= 1'h1;
      bus(1'h0, 32'h008, 32'h0);
      chk("frozen write", 32'h0, rd);
      summarize;
   end
endmodule
